// ==== include/vcpc_cfg.svh ====
// Constants of the voice codec serial-port block: offsets, fields, counts.
// Assumes inclusion by bare name from every file that uses the macros.
`ifndef VCPC_CFG_SVH
`define VCPC_CFG_SVH
// Bit clocks per frame and idle frames before standby or test
`define VCPC_FRAME_CLKS 256
`define VCPC_IDLE_FRAMES 5
// Register byte offsets
`define VCPC_REG_STATUS 4'h0
`define VCPC_REG_TX 4'h4
`define VCPC_REG_RX 4'h8
// Status register fields
`define VCPC_ST_RX_STANDBY 0
`define VCPC_ST_TX_STANDBY 1
`define VCPC_ST_TEST 2
`define VCPC_ST_RX_VALID 3
`define VCPC_ST_POWER_DOWN 4
`define VCPC_ST_COMPANDED 5
`define VCPC_ST_FIXED_RATE 6
`define VCPC_ST_TX_PIN 7
// Positions of the control pins inside the synchroniser vectors
`define VCPC_PIN_PD 0
`define VCPC_PIN_MIC 1
`define VCPC_PIN_EAR 2
`define VCPC_PIN_CODE 3
`define VCPC_PIN_RATE 4
`define VCPC_PIN_TXP 5
`define VCPC_PIN_W 6
// Word lengths, linear data-bit count and zero codes
`define VCPC_LIN_BITS 5'h10
`define VCPC_CMP_BITS 5'h08
`define VCPC_LIN_DATA_BITS 5'h0D
`define VCPC_ZERO_LINEAR 16'h0000
`define VCPC_ZERO_MULAW 8'hFF
`define VCPC_ZERO_ALAW 8'hD5
`define VCPC_RESET_WORD 16'h0000
`endif

// ==== include/vcpc_pkg.sv ====
// Types shared by the voice codec serial-port block.
// Assumes nothing of its surroundings.
package vcpc_pkg;
    typedef enum logic {
        VCPC_LINEAR = 1'b0,
        VCPC_COMPANDED = 1'b1
    } vcpc_coding_t;
    typedef logic [15:0] vcpc_word_t;
endpackage

// ==== core/vcpc_frame_ctl.sv ====
// Per-channel framing: sync, idle detection and slot bit counting.
// Assumes the frame-sync pin is asynchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
`include "vcpc_cfg.svh"
module vcpc_frame_ctl
    import vcpc_pkg::*;
#(
    parameter int FRAME_CLKS = `VCPC_FRAME_CLKS,
    parameter int IDLE_FRAMES = `VCPC_IDLE_FRAMES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_fs_pin,
    input wire logic i_power_down,
    input wire logic i_variable,
    input wire logic [4:0] i_word_bits,
    output logic o_bit_ok,
    output logic [4:0] o_bit_idx,
    output logic o_last_bit,
    output logic o_standby,
    output logic o_test
);
    localparam int LIMIT = FRAME_CLKS * IDLE_FRAMES;
    localparam int CW = $clog2(LIMIT + 1);
    logic fs_s1, fs_s2, fs_d;
    logic in_slot;
    logic [CW-1:0] run_cnt;
    logic rise, fall, run_done;

    assign rise = fs_s2 & ~fs_d;
    assign fall = ~fs_s2 & fs_d;
    assign run_done = run_cnt == CW'(LIMIT - 1);
    // fs_d lines up with the data bit being handled this cycle
    assign o_bit_ok = in_slot & (~i_variable | fs_d);
    assign o_last_bit = o_bit_ok & (o_bit_idx == i_word_bits - 5'h01);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            fs_s1 <= 1'b0;
            fs_s2 <= 1'b0;
            fs_d <= 1'b0;
        end else begin
            fs_s1 <= i_fs_pin;
            fs_s2 <= fs_s1;
            fs_d <= fs_s2;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            run_cnt <= '0;
        end else if (i_power_down || fs_s2 != fs_d) begin
            run_cnt <= '0;
        end else if (!run_done) begin
            run_cnt <= run_cnt + CW'(1);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_standby <= 1'b0;
            o_test <= 1'b0;
        end else begin
            if (rise) begin
                o_standby <= 1'b0;
            end else if (!fs_s2 && run_done) begin
                o_standby <= 1'b1;
            end
            if (fall) begin
                o_test <= 1'b0;
            end else if (fs_s2 && run_done) begin
                o_test <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            in_slot <= 1'b0;
            o_bit_idx <= 5'h00;
        end else if (i_power_down) begin
            in_slot <= 1'b0;
            o_bit_idx <= 5'h00;
        end else if (rise) begin
            in_slot <= 1'b1;
            o_bit_idx <= 5'h00;
        end else if (in_slot) begin
            // A variable-rate sync dropping early cuts the slot short
            if (o_last_bit || !o_bit_ok) begin
                in_slot <= 1'b0;
            end
            o_bit_idx <= o_bit_idx + 5'h01;
        end
    end

    a_standby_set: assert property (@(posedge i_clk)
        disable iff (i_rst) !fs_s2 && run_done |=> o_standby)
        else $error("standby not entered after idle frames");
    a_test_set: assert property (@(posedge i_clk)
        disable iff (i_rst) fs_s2 && run_done && !fall |=> o_test)
        else $error("test condition not entered");
    a_resume_sync: assert property (@(posedge i_clk)
        disable iff (i_rst) rise |=> !o_standby ##0
        (in_slot || $past(i_power_down)))
        else $error("channel did not resume on sync pulse");
    a_slot_end: assert property (@(posedge i_clk)
        disable iff (i_rst) o_last_bit && !rise |=> !in_slot)
        else $error("slot ran past word length");
endmodule
`default_nettype wire

// ==== core/vcpc_top.sv ====
// Top of the voice codec serial-port block: Avalon-MM slave and PCM link.
// Assumes i_link_clk is the active bit clock in either data-rate mode.
//
// Overview of operation
// - Earphone silence input low disables earphone
// - Receive sync low five frames: receive standby
// - Transmit sync low five frames: transmit standby
// - Either sync high five frames: test mode
// - Transmit framing independent of receive framing
// - Coding select low linear, high companded
// - Microphone silence low sends zero code
// - Power-down low stops conversion and serial activity
// - Fixed rate: strobe pin pulls low in slot
// - Variable rate: strobe pin is transmit clock input (here only sampled into status; i_link_clk clocks transmit)
// - Rate pin high selects fixed rate
// - Receive data sampled on falling bit clock
// - Transmit data shifted on rising bit clock
// - Companded eight bits, linear sixteen bits
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "vcpc_cfg.svh"
module vcpc_top
    import vcpc_pkg::*;
#(
    parameter int FRAME_CLKS = `VCPC_FRAME_CLKS,
    parameter int IDLE_FRAMES = `VCPC_IDLE_FRAMES,
    parameter bit COMPAND_ALAW = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_link_clk,
    input wire logic i_rx_frame_sync,
    input wire logic i_tx_frame_sync,
    input wire logic i_rx_data,
    output logic o_tx_data,
    input wire logic i_rx_bit_clock_or_rate_select,
    input wire logic i_tx_slot_strobe_or_clock,
    output logic o_tx_slot_strobe_or_clock,
    output logic o_tx_slot_strobe_or_clock_oe,
    input wire logic i_power_down_n,
    input wire logic i_mic_silence_n,
    input wire logic i_earphone_silence_n,
    input wire logic i_coding_select,
    output logic o_earphone_enable,
    output logic o_power_down,
    output logic o_test_mode
);
    logic [`VCPC_PIN_W-1:0] pins;
    logic [`VCPC_PIN_W-1:0] sys_pin_s1, sys_pin_s2;
    logic [`VCPC_PIN_W-1:0] lk_pin_s1, lk_pin_s2;
    logic [2:0] sys_st_s1, sys_st_s2;
    logic [31:0] next_readdata;
    vcpc_word_t tx_staging, tx_hold, tx_word, rx_sample, rx_hold, rx_shift;
    vcpc_word_t next_rx;
    logic tx_req, tx_pending, sys_ack_s1, sys_ack_s2;
    logic lk_req_s1, lk_req_s2, lk_req_s3;
    logic sys_rxt_s1, sys_rxt_s2, sys_rxt_s3, rx_new, rx_valid, rx_tgl;
    logic rd_serve;
    logic lk_rst_s1, lk_rst;
    logic lk_pd, lk_fixed;
    vcpc_coding_t lk_coding;
    logic [4:0] word_bits;
    logic tx_ok, tx_sb, tx_test;
    logic rx_ok, rx_last, rx_sb, rx_test;
    logic [4:0] tx_idx;
    logic [3:0] tx_sel;
    logic [7:0] zero_cmp;
    logic rx_clk;
    logic din_s1, din_s2, din_s3;

    assign pins = {i_tx_slot_strobe_or_clock, i_rx_bit_clock_or_rate_select,
                   i_coding_select, i_earphone_silence_n, i_mic_silence_n,
                   i_power_down_n};

    // System clock domain

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sys_pin_s1 <= '0;
            sys_pin_s2 <= '0;
            sys_st_s1 <= 3'h0;
            sys_st_s2 <= 3'h0;
        end else begin
            sys_pin_s1 <= pins;
            sys_pin_s2 <= sys_pin_s1;
            sys_st_s1 <= {tx_test | rx_test, tx_sb, rx_sb};
            sys_st_s2 <= sys_st_s1;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_earphone_enable <= 1'b0;
            o_power_down <= 1'b1;
            o_test_mode <= 1'b0;
        end else begin
            o_earphone_enable <= sys_pin_s2[`VCPC_PIN_EAR] &
                                 sys_pin_s2[`VCPC_PIN_PD];
            o_power_down <= ~sys_pin_s2[`VCPC_PIN_PD];
            o_test_mode <= sys_st_s2[2];
        end
    end

    always_comb begin
        next_readdata = 32'h0000_0000;
        if (i_avs_address == `VCPC_REG_STATUS) begin
            next_readdata[`VCPC_ST_RX_STANDBY] = sys_st_s2[0];
            next_readdata[`VCPC_ST_TX_STANDBY] = sys_st_s2[1];
            next_readdata[`VCPC_ST_TEST] = sys_st_s2[2];
            next_readdata[`VCPC_ST_RX_VALID] = rx_valid;
            next_readdata[`VCPC_ST_POWER_DOWN] = ~sys_pin_s2[`VCPC_PIN_PD];
            next_readdata[`VCPC_ST_COMPANDED] = sys_pin_s2[`VCPC_PIN_CODE];
            next_readdata[`VCPC_ST_FIXED_RATE] = sys_pin_s2[`VCPC_PIN_RATE];
            next_readdata[`VCPC_ST_TX_PIN] = sys_pin_s2[`VCPC_PIN_TXP];
        end else if (i_avs_address == `VCPC_REG_TX) begin
            next_readdata[15:0] = tx_staging;
        end else if (i_avs_address == `VCPC_REG_RX) begin
            next_readdata[15:0] = rx_sample;
        end
    end

    assign rd_serve = i_avs_read & o_avs_waitrequest;

    // A transmit-word write stalls until the link side has taken it,
    // so the staging word never changes while it is crossing
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h0000_0000;
            tx_staging <= `VCPC_RESET_WORD;
            tx_req <= 1'b0;
            tx_pending <= 1'b0;
        end else begin
            o_avs_waitrequest <= 1'b1;
            if (rd_serve) begin
                o_avs_readdata <= next_readdata;
                o_avs_waitrequest <= 1'b0;
            end else if (i_avs_write && o_avs_waitrequest) begin
                if (i_avs_address == `VCPC_REG_TX) begin
                    if (!tx_pending) begin
                        if (i_avs_byteenable[0]) begin
                            tx_staging[7:0] <= i_avs_writedata[7:0];
                        end
                        if (i_avs_byteenable[1]) begin
                            tx_staging[15:8] <= i_avs_writedata[15:8];
                        end
                        tx_req <= ~tx_req;
                        tx_pending <= 1'b1;
                    end else if (sys_ack_s2 == tx_req) begin
                        tx_pending <= 1'b0;
                        o_avs_waitrequest <= 1'b0;
                    end
                end else begin
                    o_avs_waitrequest <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sys_ack_s1 <= 1'b0;
            sys_ack_s2 <= 1'b0;
            sys_rxt_s1 <= 1'b0;
            sys_rxt_s2 <= 1'b0;
            sys_rxt_s3 <= 1'b0;
        end else begin
            sys_ack_s1 <= lk_req_s3;
            sys_ack_s2 <= sys_ack_s1;
            sys_rxt_s1 <= rx_tgl;
            sys_rxt_s2 <= sys_rxt_s1;
            sys_rxt_s3 <= sys_rxt_s2;
        end
    end

    assign rx_new = sys_rxt_s2 ^ sys_rxt_s3;

    // rx_hold is stable for a whole word after its toggle, so it is copied
    // here without a second handshake
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rx_sample <= `VCPC_RESET_WORD;
            rx_valid <= 1'b0;
        end else begin
            if (rx_new) begin
                rx_sample <= rx_hold;
                rx_valid <= 1'b1;
            end else if (rd_serve && i_avs_address == `VCPC_REG_RX) begin
                rx_valid <= 1'b0;
            end
        end
    end

    // Link clock domain, rising edge: transmit side

    always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            lk_rst_s1 <= 1'b1;
            lk_rst <= 1'b1;
        end else begin
            lk_rst_s1 <= 1'b0;
            lk_rst <= lk_rst_s1;
        end
    end

    always_ff @(posedge i_link_clk or posedge lk_rst) begin
        if (lk_rst) begin
            lk_pin_s1 <= '0;
            lk_pin_s2 <= '0;
            lk_req_s1 <= 1'b0;
            lk_req_s2 <= 1'b0;
            lk_req_s3 <= 1'b0;
            tx_hold <= `VCPC_RESET_WORD;
        end else begin
            lk_pin_s1 <= pins;
            lk_pin_s2 <= lk_pin_s1;
            lk_req_s1 <= tx_req;
            lk_req_s2 <= lk_req_s1;
            lk_req_s3 <= lk_req_s2;
            if (lk_req_s2 != lk_req_s3) begin
                tx_hold <= tx_staging;
            end
        end
    end

    assign lk_pd = ~lk_pin_s2[`VCPC_PIN_PD];
    assign lk_fixed = lk_pin_s2[`VCPC_PIN_RATE];
    assign lk_coding = vcpc_coding_t'(lk_pin_s2[`VCPC_PIN_CODE]);
    assign word_bits = (lk_coding == VCPC_COMPANDED) ? `VCPC_CMP_BITS :
                       `VCPC_LIN_BITS;
    assign zero_cmp = COMPAND_ALAW ? `VCPC_ZERO_ALAW : `VCPC_ZERO_MULAW;

    // Separate framing for each direction
    vcpc_frame_ctl #(
        .FRAME_CLKS(FRAME_CLKS),
        .IDLE_FRAMES(IDLE_FRAMES)
    ) u_tx_frame (
        .i_clk(i_link_clk),
        .i_rst(lk_rst),
        .i_fs_pin(i_tx_frame_sync),
        .i_power_down(lk_pd),
        .i_variable(~lk_fixed),
        .i_word_bits(word_bits),
        .o_bit_ok(tx_ok),
        .o_bit_idx(tx_idx),
        .o_last_bit(),
        .o_standby(tx_sb),
        .o_test(tx_test)
    );

    always_comb begin
        if (!lk_pin_s2[`VCPC_PIN_MIC]) begin
            tx_word = (lk_coding == VCPC_COMPANDED) ? {8'h00, zero_cmp} :
                      `VCPC_ZERO_LINEAR;
        end else if (lk_coding == VCPC_COMPANDED) begin
            tx_word = {8'h00, tx_hold[7:0]};
        end else begin
            tx_word = {tx_hold[15:3], 3'b000};
        end
    end

    assign tx_sel = 4'(word_bits - 5'h01 - tx_idx);

    // Transmit data has no enable here; it rests low outside the slot
    always_ff @(posedge i_link_clk or posedge lk_rst) begin
        if (lk_rst) begin
            o_tx_data <= 1'b0;
            o_tx_slot_strobe_or_clock <= 1'b0;
            o_tx_slot_strobe_or_clock_oe <= 1'b0;
        end else begin
            o_tx_data <= tx_ok ? tx_word[tx_sel] : 1'b0;
            o_tx_slot_strobe_or_clock <= 1'b0;
            // Open drain: only ever pulls low, and only in fixed rate
            o_tx_slot_strobe_or_clock_oe <= lk_fixed & tx_ok;
        end
    end

    // Link clock domain, falling edge: receive side

    assign rx_clk = ~i_link_clk;

    vcpc_frame_ctl #(
        .FRAME_CLKS(FRAME_CLKS),
        .IDLE_FRAMES(IDLE_FRAMES)
    ) u_rx_frame (
        .i_clk(rx_clk),
        .i_rst(lk_rst),
        .i_fs_pin(i_rx_frame_sync),
        .i_power_down(lk_pd),
        .i_variable(~lk_fixed),
        .i_word_bits(word_bits),
        .o_bit_ok(rx_ok),
        .o_bit_idx(),
        .o_last_bit(rx_last),
        .o_standby(rx_sb),
        .o_test(rx_test)
    );

    assign next_rx = {rx_shift[14:0], din_s3};

    always_ff @(negedge i_link_clk or posedge lk_rst) begin
        if (lk_rst) begin
            din_s1 <= 1'b0;
            din_s2 <= 1'b0;
            din_s3 <= 1'b0;
            rx_shift <= `VCPC_RESET_WORD;
            rx_hold <= `VCPC_RESET_WORD;
            rx_tgl <= 1'b0;
        end else begin
            // Third stage keeps data aligned with the synced frame sync
            din_s1 <= i_rx_data;
            din_s2 <= din_s1;
            din_s3 <= din_s2;
            if (rx_ok) begin
                rx_shift <= next_rx;
            end
            if (rx_last) begin
                rx_hold <= (lk_coding == VCPC_COMPANDED) ?
                           {8'h00, next_rx[7:0]} : next_rx;
                rx_tgl <= ~rx_tgl;
            end
        end
    end

    a_ear_mute: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) !sys_pin_s2[`VCPC_PIN_EAR] |=>
        !o_earphone_enable) else $error("earphone enabled while silenced");
    a_pd_quiet: assert property (@(posedge i_link_clk)
        disable iff (lk_rst) lk_pd ##1 lk_pd |=> !o_tx_data &&
        !o_tx_slot_strobe_or_clock_oe) else $error("power-down activity");
    a_mic_zero: assert property (@(posedge i_link_clk)
        disable iff (lk_rst) tx_ok && !lk_pin_s2[`VCPC_PIN_MIC] &&
        lk_coding == VCPC_LINEAR |=> !o_tx_data)
        else $error("nonzero bit sent while microphone silenced");
    a_strobe_slot: assert property (@(posedge i_link_clk)
        disable iff (lk_rst) lk_fixed && tx_ok |=>
        o_tx_slot_strobe_or_clock_oe && !o_tx_slot_strobe_or_clock)
        else $error("strobe not pulled low in slot");
    a_strobe_input: assert property (@(posedge i_link_clk)
        disable iff (lk_rst) !lk_fixed |=> !o_tx_slot_strobe_or_clock_oe)
        else $error("strobe pin driven in variable rate");
    a_linear_pad: assert property (@(posedge i_link_clk)
        disable iff (lk_rst) tx_ok && lk_coding == VCPC_LINEAR &&
        tx_idx >= `VCPC_LIN_DATA_BITS |=> !o_tx_data)
        else $error("pad bit not zero");
    a_tx_first_bit: assert property (@(posedge i_link_clk)
        disable iff (lk_rst)
        tx_ok && tx_idx == 5'h00 && lk_coding == VCPC_COMPANDED &&
        lk_pin_s2[`VCPC_PIN_MIC] |=> o_tx_data == $past(tx_hold[7]))
        else $error("first companded bit not word MSB");
    a_rx_capture: assert property (@(negedge i_link_clk)
        disable iff (lk_rst) rx_last |=> rx_hold[0] == $past(din_s3) &&
        rx_tgl != $past(rx_tgl))
        else $error("received word not captured");
    a_read_answer: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        rd_serve |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("read not answered in one cycle");
endmodule
`default_nettype wire

// ==== tb/vcpc_host_model.sv ====
// Host PCM port model: frame syncs, receive data, transmit slot capture.
// Assumes one shared link clock serves both bit clocks.
`timescale 1ns/1ps
`default_nettype none
module vcpc_host_model #(
    parameter int FRAME_CLKS = 32
) (
    input wire logic i_link_clk,
    input wire logic i_rst,
    input wire logic i_var,
    input wire logic [4:0] i_bits,
    input wire logic [15:0] i_rx_word,
    input wire logic [1:0] i_rx_mode,
    input wire logic [1:0] i_tx_mode,
    input wire logic i_tx_data,
    input wire logic i_strobe_oe,
    output logic o_rx_fs,
    output logic o_tx_fs,
    output logic o_rx_data,
    output logic [15:0] o_tx_word,
    output logic [4:0] o_tx_bits,
    output logic [7:0] o_slots
);
    logic [7:0] cnt;
    logic [15:0] sh;
    logic [4:0] nb;
    logic prev_oe;
    logic pulse;
    // Fixed rate: one-clock pulse; variable rate: high whole slot
    assign pulse = cnt < (i_var ? 8'(i_bits) : 8'h01);
    assign o_rx_fs = i_rx_mode == 2'h0 ? pulse : i_rx_mode[1];
    assign o_tx_fs = i_tx_mode == 2'h0 ? pulse : i_tx_mode[1];
    // Bits change after rising edges, stable at falling; a toggle after
    assign o_rx_data = cnt < 8'(i_bits) ?
        i_rx_word[4'(i_bits - 5'h01 - cnt[4:0])] : cnt[0];
    always_ff @(posedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt <= 8'h00;
        end else begin
            cnt <= cnt == 8'(FRAME_CLKS - 1) ? 8'h00 : cnt + 8'h01;
        end
    end
    // Strobe marks the slot; one captured bit per falling edge
    always_ff @(negedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            prev_oe <= 1'b0;
            sh <= 16'h0000;
            nb <= 5'h00;
            o_tx_word <= 16'h0000;
            o_tx_bits <= 5'h00;
            o_slots <= 8'h00;
        end else begin
            prev_oe <= i_strobe_oe;
            if (i_strobe_oe) begin
                sh <= prev_oe ? {sh[14:0], i_tx_data} : {15'h0, i_tx_data};
                nb <= prev_oe ? nb + 5'h01 : 5'h01;
            end else if (prev_oe) begin
                o_tx_word <= sh;
                o_tx_bits <= nb;
                o_slots <= o_slots + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Bench of the codec serial-port block: register bus, pins, host port.
// Assumes the host model drives frames on the free-running link clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import vcpc_pkg::*;
;
    localparam int FCLK = 32;
    typedef struct {
        vcpc_coding_t code;
        logic mic_n;
        logic [15:0] tx, rxw, exp_tx;
        logic [4:0] bits;
    } vcpc_row_t;
    vcpc_row_t rows [4] = '{
        '{VCPC_LINEAR, 1'b1, 16'hABCD, 16'h5A3C, 16'hABC8, 5'h10},
        '{VCPC_COMPANDED, 1'b1, 16'h1234, 16'h00C3, 16'h0034, 5'h08},
        '{VCPC_LINEAR, 1'b0, 16'hFFFF, 16'h8001, 16'h0000, 5'h10},
        '{VCPC_COMPANDED, 1'b0, 16'h1234, 16'h007E, 16'h00FF, 5'h08}};
    logic clk = 1'b0, rst = 1'b1, link_clk = 1'b0, rd_en = 1'b0;
    logic wr_en = 1'b0, rate = 1'b1, pd_n = 1'b1, mic_n = 1'b1;
    logic ear_n = 1'b1, vr = 1'b0, pin;
    vcpc_coding_t code = VCPC_LINEAR;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, r;
    logic [4:0] bits = 5'h10, tx_bits;
    logic [15:0] rxw = 16'h0, tx_word;
    logic [1:0] rxm = 2'h0, txm = 2'h0;
    logic [7:0] slots, s;
    logic wreq, txd, stb, oe, ear_en, pdo, tmode, rfs, tfs, din;
    int err_count = 0, n_tests = 0;
    always #50 clk = ~clk;
    initial begin
        #13;
        forever #62.5 link_clk = ~link_clk;
    end
    // Pulled up when released; host clock on it in variable rate
    assign pin = rate ? !oe : link_clk;
    vcpc_top #(.FRAME_CLKS(FCLK), .IDLE_FRAMES(5), .COMPAND_ALAW(1'b0))
    i_dut (.i_clk(clk), .i_sys_rst(rst), .i_avs_address(addr),
        .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata),
        .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq), .i_link_clk(link_clk),
        .i_rx_frame_sync(rfs), .i_tx_frame_sync(tfs), .i_rx_data(din),
        .o_tx_data(txd), .i_rx_bit_clock_or_rate_select(rate),
        .i_tx_slot_strobe_or_clock(pin), .o_tx_slot_strobe_or_clock(stb),
        .o_tx_slot_strobe_or_clock_oe(oe), .i_power_down_n(pd_n),
        .i_mic_silence_n(mic_n), .i_earphone_silence_n(ear_n),
        .i_coding_select(code), .o_earphone_enable(ear_en),
        .o_power_down(pdo), .o_test_mode(tmode));
    vcpc_host_model #(.FRAME_CLKS(FCLK)) i_host (.i_link_clk(link_clk),
        .i_rst(rst), .i_var(vr), .i_bits(bits), .i_rx_word(rxw),
        .i_rx_mode(rxm), .i_tx_mode(txm), .i_tx_data(txd),
        .i_strobe_oe(oe), .o_rx_fs(rfs), .o_tx_fs(tfs), .o_rx_data(din),
        .o_tx_word(tx_word), .o_tx_bits(tx_bits), .o_slots(slots));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // No fixed latency assumed; the bound only catches a hang
    task automatic bus(input logic w, input logic [3:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= w;
        rd_en <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 200);
        r = rdata;
        chk(n < 200, 1'b1);
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask
    task automatic frames(input int n);
        repeat (n * FCLK) @(posedge link_clk);
        @(posedge clk);
    endtask
    task automatic finish_test;
        if (err_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #800000;
        err_count++;
        $display("mismatch at %0t: run did not finish", $time);
        finish_test;
    end
    initial begin
        repeat (2) @(posedge clk);
        chk({wreq, pdo, ear_en, oe, stb, tmode, txd}, 7'b1100000);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            code <= rows[i].code;
            mic_n <= rows[i].mic_n;
            bits <= rows[i].bits;
            rxw <= rows[i].rxw;
            bus(1'b1, 4'h4, {16'h0, rows[i].tx});
            frames(4);
            chk(tx_word, rows[i].exp_tx);
            chk(tx_bits, rows[i].bits);
            bus(1'b0, 4'h0, 32'h0);
            chk(r[6:3], {1'b1, rows[i].code, 2'b01});
            bus(1'b0, 4'h8, 32'h0);
            chk(r, {16'h0, rows[i].rxw});
        end
        ear_n <= 1'b0;
        repeat (5) @(posedge clk);
        chk(ear_en, 1'b0);
        ear_n <= 1'b1;
        repeat (5) @(posedge clk);
        chk(ear_en, 1'b1);
        pd_n <= 1'b0;
        frames(2);
        s = slots;
        frames(3);
        chk({slots, pdo, ear_en}, {s, 2'b10});
        pd_n <= 1'b1;
        frames(3);
        chk(slots != s, 1'b1);
        rxm <= 2'h1;
        frames(7);
        bus(1'b0, 4'h0, 32'h0);
        chk(r[2:0], 3'b001);
        txm <= 2'h1;
        frames(7);
        bus(1'b0, 4'h0, 32'h0);
        chk(r[2:0], 3'b011);
        rxm <= 2'h0;
        txm <= 2'h0;
        frames(2);
        bus(1'b0, 4'h0, 32'h0);
        chk(r[2:0], 3'b000);
        rxm <= 2'h2;
        frames(7);
        chk(tmode, 1'b1);
        rxm <= 2'h0;
        frames(2);
        bus(1'b1, 4'hC, 32'hFFFF_FFFF);
        bus(1'b0, 4'hC, 32'h0);
        chk(r, 32'h0);
        rate <= 1'b0;
        vr <= 1'b1;
        rxw <= 16'h00A5;
        frames(4);
        bus(1'b0, 4'h8, 32'h0);
        chk(r, 32'h0000_00A5);
        bus(1'b0, 4'h0, 32'h0);
        chk({r[6], oe, stb}, 3'b000);
        finish_test;
    end
endmodule
`default_nettype wire
